// ===== logic/ppo_prescaled_pwm_output_unit.sv
// top: axi4-lite registers, shared prescaler and pwm submodule
`timescale 1ns/1ns
module ppo_prescaled_pwm_output_unit
    import ppo_pkg::*;
#(
    parameter int PERIOD_W = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pwm_pin_sense,
    output logic             pwm_pin_output,
    output logic             prescaled_tick,
    output logic             period_flag
);
    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    generate
        if (PERIOD_W < 2 || PERIOD_W > 16) begin : g_bad_width
            $error("PERIOD_W must be 2..16 to fit one register word");
        end
    endgenerate

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        logic                aw_got;
        logic [11:0]         waddr;
        logic                w_got;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic [3:0]          div;
        logic                run;
        logic [4:0]          cnt;
        logic                tick;
        logic [7:0]          cp;
        logic                pwm_en;
        logic [PERIOD_W-1:0] period;
        logic [PERIOD_W-1:0] pulse;
        logic                flag;
    } ppo_top_st_t;

    ppo_top_st_t st_ff;
    ppo_top_st_t nxt_st;
    logic        wr_go;
    logic [31:0] psc_img;
    logic [31:0] ctrl_img;
    logic [31:0] merged;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        pin_state;
    logic        flag_evt;
    logic        pin_q;

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    always_comb begin
        psc_img                                 = '0;
        psc_img[PPO_DIV_LSB +: PPO_DIV_W]       = st_ff.div;
        psc_img[PPO_RUN_BIT]                    = st_ff.run;
        ctrl_img                                = '0;
        ctrl_img[PPO_CP_LSB +: PPO_CP_W]        = st_ff.cp;
        ctrl_img[PPO_EN_BIT]                    = st_ff.pwm_en;
        ctrl_img[PPO_PIN_BIT]                   = pin_state;
        ctrl_img[PPO_FLAG_BIT]                  = st_ff.flag;
    end

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            PPO_PSC_OFF: begin
                rd_word = psc_img;
            end
            PPO_CTRL_OFF: begin
                rd_word = ctrl_img;
            end
            PPO_PERIOD_OFF: begin
                rd_word[PERIOD_W-1:0] = st_ff.period;
            end
            PPO_PULSE_OFF: begin
                rd_word[PERIOD_W-1:0] = st_ff.pulse;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state: bus slave, prescaler, control bits
    // ------------------------------------------------------------
    always_comb begin
        nxt_st      = st_ff;
        merged      = '0;
        wr_go       = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        nxt_st.tick = 1'b0;
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // reload takes the divide in force at the reload edge
        if (st_ff.run) begin
            if (st_ff.cnt <= 5'h01) begin
                nxt_st.cnt  = ppo_eff_div(st_ff.div);
                nxt_st.tick = (st_ff.div != PPO_DIV_OFF);
            end else begin
                nxt_st.cnt = st_ff.cnt - 5'h01;
            end
        end
        if (wr_go) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = PPO_RESP_OKAY;
            case (st_ff.waddr)
                PPO_PSC_OFF: begin
                    merged     = ppo_merge(psc_img, st_ff.wdata, st_ff.wstrb);
                    nxt_st.div = merged[PPO_DIV_LSB +: PPO_DIV_W];
                    nxt_st.run = merged[PPO_RUN_BIT];
                    if (merged[PPO_RUN_BIT] && !st_ff.run) begin
                        // old divide counts first; new one at next reload
                        nxt_st.cnt  = ppo_eff_div(st_ff.div) - 5'h01;
                        nxt_st.tick = 1'b0;
                    end
                end
                PPO_CTRL_OFF: begin
                    merged        = ppo_merge(ctrl_img, st_ff.wdata, st_ff.wstrb);
                    nxt_st.cp     = merged[PPO_CP_LSB +: PPO_CP_W];
                    nxt_st.pwm_en = merged[PPO_EN_BIT];
                    if (st_ff.wstrb[PPO_FLAG_BIT/8] && st_ff.wdata[PPO_FLAG_BIT]) begin
                        nxt_st.flag = 1'b0;
                    end
                end
                PPO_PERIOD_OFF: begin
                    merged        = ppo_merge({{(32-PERIOD_W){1'b0}}, st_ff.period},
                                              st_ff.wdata, st_ff.wstrb);
                    nxt_st.period = merged[PERIOD_W-1:0];
                end
                PPO_PULSE_OFF: begin
                    merged       = ppo_merge({{(32-PERIOD_W){1'b0}}, st_ff.pulse},
                                             st_ff.wdata, st_ff.wstrb);
                    nxt_st.pulse = merged[PERIOD_W-1:0];
                end
                default: begin
                    nxt_st.bresp = PPO_RESP_SLV;
                end
            endcase
        end
        // a flag event (count entering the last) in the clearing cycle is kept
        if (flag_evt) begin
            nxt_st.flag = 1'b1;
        end
        nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
        nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_word;
            nxt_st.rresp  = rd_hit ? PPO_RESP_OKAY : PPO_RESP_SLV;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.arready = !nxt_st.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // pwm submodule
    // ------------------------------------------------------------
    ppo_pwm_channel #(
        .PERIOD_W (PERIOD_W)
    ) u_pwm (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .prescaled_tick    (st_ff.tick),
        .pwm_enable        (st_ff.pwm_en),
        .pwm_clock_preload (st_ff.cp),
        .pwm_period_value  (st_ff.period),
        .pwm_pulse_value   (st_ff.pulse),
        .pwm_pin_sense     (pwm_pin_sense),
        .pwm_pin_output    (pin_q),
        .pwm_pin_state_bit (pin_state),
        .period_flag_pulse (flag_evt)
    );

    assign s_axi_awready  = st_ff.awready;
    assign s_axi_wready   = st_ff.wready;
    assign s_axi_bvalid   = st_ff.bvalid;
    assign s_axi_bresp    = st_ff.bresp;
    assign s_axi_arready  = st_ff.arready;
    assign s_axi_rvalid   = st_ff.rvalid;
    assign s_axi_rresp    = st_ff.rresp;
    assign s_axi_rdata    = st_ff.rdata;
    assign prescaled_tick = st_ff.tick;
    assign period_flag    = st_ff.flag;
    assign pwm_pin_output = pin_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DIV_RESET: assert property (@(posedge aclk)
        !aresetn |=> (st_ff.div == PPO_DIV_RST && !st_ff.run))
        else $error("divide field not zero after reset");
    AST_DIV1_SILENT: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.div == PPO_DIV_OFF) |=> !st_ff.tick)
        else $error("tick seen with divide field one");
    AST_TICK_SINGLE: assert property (@(posedge aclk) disable iff (!aresetn)
        st_ff.tick |=> !st_ff.tick)
        else $error("prescaled tick longer than one cycle");
    AST_FIRST_TICK16: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(st_ff.run) && $past(st_ff.div) == PPO_DIV_RST)
        |-> ##15 (st_ff.tick || !st_ff.run))
        else $error("first tick not fifteen cycles after enable");
    AST_FIRST_TICK2: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(st_ff.run) && $past(st_ff.div) == 4'h2) |=> st_ff.tick)
        else $error("first tick not one cycle after enable");
    AST_PERIOD2: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.tick && $past(st_ff.div) == 4'h2 && st_ff.run) ##1 st_ff.run
        |=> st_ff.tick)
        else $error("divide two does not tick every second cycle");
    AST_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_evt |=> st_ff.flag)
        else $error("period flag event lost");
endmodule

// ===== include/ppo_pkg.sv
// constants shared by the prescaled pwm output unit
package ppo_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] PPO_PSC_OFF    = 12'h000;
    localparam logic [11:0] PPO_CTRL_OFF   = 12'h004;
    localparam logic [11:0] PPO_PERIOD_OFF = 12'h008;
    localparam logic [11:0] PPO_PULSE_OFF  = 12'h00c;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PPO_DIV_LSB  = 0;
    localparam int PPO_DIV_W    = 4;
    localparam int PPO_RUN_BIT  = 7;
    localparam int PPO_CP_LSB   = 0;
    localparam int PPO_CP_W     = 8;
    localparam int PPO_EN_BIT   = 8;
    localparam int PPO_PIN_BIT  = 16;
    localparam int PPO_FLAG_BIT = 17;
    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [3:0]  PPO_DIV_RST    = 4'h0;
    localparam logic [3:0]  PPO_DIV_OFF    = 4'h1;
    localparam logic [4:0]  PPO_DIV_ZERO   = 5'h10;
    localparam logic [7:0]  PPO_CP_RST     = 8'h00;
    localparam logic [7:0]  PPO_CP_TOP     = 8'hff;
    localparam logic [1:0]  PPO_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  PPO_RESP_SLV   = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PPO_CLK_HZ       = 20_000_000;
    localparam int PPO_MIN_PULSE_CY = 2;
    localparam int PPO_PIN_LAT_CY   = 1;

    // divide field to divisor: zero means sixteen
    function automatic logic [4:0] ppo_eff_div(input logic [3:0] d);
        ppo_eff_div = (d == PPO_DIV_RST) ? PPO_DIV_ZERO : {1'b0, d};
    endfunction

    // byte-lane merge of a write into an old register image
    function automatic logic [31:0] ppo_merge(input logic [31:0] o,
                                              input logic [31:0] n,
                                              input logic [3:0]  s);
        ppo_merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                ppo_merge[i*8 +: 8] = n[i*8 +: 8];
            end
        end
    endfunction
endpackage

// ===== logic/ppo_pwm_channel.sv
// pwm submodule: preload divider, period counter, pin readback
`timescale 1ns/1ns
module ppo_pwm_channel
    import ppo_pkg::*;
#(
    parameter int PERIOD_W = 16
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                prescaled_tick,
    input  wire logic                pwm_enable,
    input  wire logic [7:0]          pwm_clock_preload,
    input  wire logic [PERIOD_W-1:0] pwm_period_value,
    input  wire logic [PERIOD_W-1:0] pwm_pulse_value,
    input  wire logic                pwm_pin_sense,
    output logic                     pwm_pin_output,
    output logic                     pwm_pin_state_bit,
    output logic                     period_flag_pulse
);
    typedef struct packed {
        logic [7:0]          pc;
        logic [PERIOD_W-1:0] pcnt;
        logic                pin;
        logic                pin_st;
        logic                ev_dly;
        logic                en_q;
    } ppo_ch_st_t;

    ppo_ch_st_t          st_ff;
    ppo_ch_st_t          nxt_st;
    logic [PERIOD_W-1:0] nxt_cnt;
    logic [7:0]          pc_cur;
    logic                last;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_cnt       = st_ff.pcnt;
        last          = 1'b0;
        // a preload written together with the enable is taken on the first enabled edge
        pc_cur        = st_ff.en_q ? st_ff.pc : pwm_clock_preload;
        nxt_st.en_q   = pwm_enable;
        nxt_st.pin_st = pwm_pin_sense;
        nxt_st.ev_dly = 1'b0;
        if (!pwm_enable) begin
            // reload so the first count comes (256 - preload) ticks after enable
            nxt_st.pc   = pwm_clock_preload;
            nxt_st.pcnt = '0;
            nxt_st.pin  = 1'b0;
        end else begin
            nxt_st.pc = pc_cur;
            if (prescaled_tick) begin
                if (pc_cur == PPO_CP_TOP) begin
                    nxt_st.pc = pwm_clock_preload;
                    last = (st_ff.pcnt == pwm_period_value - 1'b1) ||
                           (pwm_period_value == '0);
                    nxt_cnt = last ? '0 : st_ff.pcnt + 1'b1;
                    nxt_st.pcnt = nxt_cnt;
                    // while enabled the output only moves on a count, so pulses last >= 2 cycles
                    if (pwm_pulse_value >= pwm_period_value) begin
                        nxt_st.pin = (pwm_pulse_value != '0);
                    end else begin
                        nxt_st.pin = (nxt_cnt >= pwm_period_value - pwm_pulse_value);
                    end
                    // raised on the count entering the last; the sticky bit adds a cycle
                    nxt_st.ev_dly = (nxt_cnt == pwm_period_value - 1'b1);
                end else begin
                    nxt_st.pc = pc_cur + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pwm_pin_output    = st_ff.pin;
    assign pwm_pin_state_bit = st_ff.pin_st;
    assign period_flag_pulse = st_ff.ev_dly;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PIN_STATE_LAT: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(pwm_pin_sense) |=> (pwm_pin_state_bit == $past(pwm_pin_sense)))
        else $error("pin state bit lags pin by other than one cycle");
    AST_MIN_PULSE_HI: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(st_ff.pin) && pwm_enable) |=> st_ff.pin)
        else $error("high pulse shorter than two cycles");
    AST_MIN_PULSE_LO: assert property (@(posedge aclk) disable iff (!aresetn)
        ($fell(st_ff.pin) && pwm_enable) |=> (!st_ff.pin || !$past(pwm_enable)))
        else $error("low pulse shorter than two cycles");
    AST_FLAG_LEADS: assert property (@(posedge aclk) disable iff (!aresetn)
        st_ff.ev_dly |-> (st_ff.pcnt == $past(pwm_period_value) - 1'b1 &&
                          (st_ff.pin || $past(pwm_pulse_value) == '0)))
        else $error("flag did not precede period start");
endmodule

// ===== dv/ppo_load_model.sv
// external load on the pwm pin: echoes the pin or holds a commanded level
`timescale 1ns/1ns
module ppo_load_model (
    input  wire logic pwm_pin_output,
    input  wire logic hold_en,
    input  wire logic hold_lvl,
    output logic      pwm_pin_sense
);
    // hold models a line pulled by something else, so readback can disagree with drive
    assign pwm_pin_sense = hold_en ? hold_lvl : pwm_pin_output;
endmodule

// ===== dv/tb.sv
// self-checking bench for the prescaled pwm output unit
`timescale 1ns/1ns
module tb;
    import ppo_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, sense, pin, tick, flag, hold_en, hold_lvl;
    logic [11:0] awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [7:0]  cp;
    logic [3:0]  dv[5] = '{4'h0, 4'h2, 4'h3, 4'h7, 4'hf};
    int          bad_count, comparisons, k, h, l, d, c, per, pul, lo, hi, n;

    ppo_prescaled_pwm_output_unit i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_pin_sense(sense),
        .pwm_pin_output(pin), .prescaled_tick(tick), .period_flag(flag));

    ppo_load_model i_load (.pwm_pin_output(pin), .hold_en(hold_en), .hold_lvl(hold_lvl),
                           .pwm_pin_sense(sense));

    always #25 aclk = ~aclk;

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic timeout();
        bad_count++;
        $display("mismatch wait expected done seen timeout");
        conclude();
    endtask

    // ------------------------------------------------------------
    // bus master and waits
    // ------------------------------------------------------------
    // leading edge keeps ready lowering and the next raise in different time steps
    task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                       output logic [1:0] r);
        int i;
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= s; awprot <= 3'($urandom);
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        int i;
        @(posedge aclk);
        araddr <= a; arprot <= 3'($urandom); arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (i == 50) timeout();
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [1:0] r;
        axw(a, v, 4'hf, r);
        check("bresp", r, PPO_RESP_OKAY);
    endtask

    // edges until the selected condition is sampled true
    task automatic wait_for(input int w, input int lim, output int k);
        logic s;
        for (k = 1; k <= lim; k++) begin
            @(posedge aclk);
            case (w)
                0: s = tick;
                1: s = pin;
                2: s = !pin;
                3: s = flag;
                default: s = !flag;
            endcase
            if (s === 1'b1) return;
        end
        timeout();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
        rready = 0; awaddr = 0; araddr = 0; awprot = 0; arprot = 0; wdata = 0;
        wstrb = 0; hold_en = 0; hold_lvl = 0; bad_count = 0; comparisons = 0;
        void'($urandom(33));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            axr(12'(4 * i), rd, rs);
            check("reset value", rd, 0);
        end
        axr(12'h010, rd, rs);
        check("unmapped rresp", rs, PPO_RESP_SLV);
        axw(12'h014, 32'hffffffff, 4'hf, rs);
        check("unmapped bresp", rs, PPO_RESP_SLV);
        wr(PPO_PERIOD_OFF, 32'hffffffff);
        axw(PPO_PERIOD_OFF, 32'h00000056, 4'h1, rs);
        axr(PPO_PERIOD_OFF, rd, rs);
        check("period byte lanes", rd, 32'h0000ff56);
        for (int v = 0; v < 2; v++) begin
            hold_en <= 1'b1;
            hold_lvl <= v[0];
            repeat (3) @(posedge aclk);
            axr(PPO_CTRL_OFF, rd, rs);
            check("pin state bit", rd[PPO_PIN_BIT], v);
        end
        hold_en <= 1'b0;
        foreach (dv[i]) begin
            wr(PPO_PSC_OFF, {28'h0, dv[i]});
            wr(PPO_PSC_OFF, {24'h0, 4'h8, dv[i]});
            d = (dv[i] == 4'h0) ? 16 : int'(dv[i]);
            wait_for(0, 40, k);
            check("first tick", k, d - 1);
            wait_for(0, 40, k);
            check("tick spacing", k, d);
            wr(PPO_PSC_OFF, 32'h0);
        end
        wr(PPO_PSC_OFF, 32'h1);
        wr(PPO_PSC_OFF, 32'h81);
        n = 0;
        repeat (40) begin
            @(posedge aclk);
            if (tick !== 1'b0) n++;
        end
        check("ticks at divide one", n, 0);
        // run set together with a new divide: old divide counts first
        wr(PPO_PSC_OFF, 32'h3);
        wr(PPO_PSC_OFF, 32'h85);
        wait_for(0, 40, k);
        check("old divide first", k, 2);
        wait_for(0, 40, k);
        check("new divide reload", k, 5);
        for (int it = 0; it < 3; it++) begin
            d = (it == 0) ? 2 : $urandom_range(4, 2);
            cp = (it == 0) ? 8'hff : 8'(255 - $urandom_range(2, 0));
            c = 256 - int'(cp);
            per = $urandom_range(6, 3);
            pul = (it == 0) ? 1 : $urandom_range(per - 1, 1);
            wr(PPO_CTRL_OFF, 32'h20000);
            wr(PPO_PSC_OFF, 32'(d));
            wr(PPO_PSC_OFF, 32'h80 | 32'(d));
            wr(PPO_PERIOD_OFF, 32'(per));
            wr(PPO_PULSE_OFF, 32'(pul));
            // enable also clears a flag left over from the previous run
            wr(PPO_CTRL_OFF, 32'h00020100 | 32'(cp));
            lo = (per - pul) * c * d + 3 + (255 - int'(cp)) * d;
            hi = lo + d - 1;
            // first set is exact only to one count, so the window widens by one count plus two cycles on each side
            wait_for(1, 2000, k);
            check("first set window", k >= lo - c * d - 2 && k <= hi + c * d + 2, 1);
            wait_for(3, 2000, k);
            wait_for(2, 2000, k);
            check("flag to pin fall", k, c * d - 1);
            wait_for(1, 2000, k);
            wait_for(2, 2000, h);
            check("high time", h, pul * c * d);
            wait_for(1, 2000, l);
            check("low time", l, (per - pul) * c * d);
        end
        conclude();
    end
endmodule
